// [dual_side_interrupt_status.sv]
// dual-side interrupt enable and status registers behind an apb slave
// assumes event pulses and queue flags come from logic on the same clock
//
// Function
// RULE1: bits 25:16 hold ten enables, default zero
// RULE2: bits 9:0 hold ten event status bits
// RULE3: writing one clears status, except bits 6, 7
// RULE4: bit 6 mirrors inbound queue not empty, read-only
// RULE5: bit 7 mirrors outbound queue not empty, read-only
// RULE6: all enables zero after reset
// RULE7: all status bits zero after reset
// RULE8: reserved bits read zero
// RULE9: host bits 3, 4: mailbox, external signal
// RULE10: local bit 3: host-to-local mailbox event
// RULE11: bits 0, 1: local and pci fifo overflow
// RULE12: bit 5: dma complete
// RULE13: bits 8, 9: target and master abort
// RULE14: enables 6, 7 gate queue not-empty events
// RULE15: interrupt output when enabled status active
// RULE16: mailbox bit write raises host mailbox event
// RULE17: soft reset clears only local bit 3
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
`include "irq_status_defs.svh"
module dual_side_interrupt_status (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // event sources, one-cycle pulses
    input wire logic local_fifo_overflow,
    input wire logic pci_fifo_overflow,
    input wire logic ext_signal_event,
    input wire logic dma_done,
    input wire logic target_abort,
    input wire logic master_abort,
    input wire logic host_write_mailbox,
    // queue flags, levels
    input wire logic inbound_queue_status,
    input wire logic outbound_queue_status,
    // soft reset request, level
    input wire logic soft_reset,
    // interrupts
    output logic pci_irq,
    output logic local_irq
);
    irq_bank_if host_side();
    irq_bank_if local_side();

    irq_status_pkg::apb_phase_t phase;
    irq_status_pkg::apb_phase_t next_phase;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic [31:0] lh_mailbox;
    logic [31:0] hl_mailbox;
    logic [31:0] next_lh_mailbox;
    logic [31:0] next_hl_mailbox;
    logic soft_reset_q;
    logic next_soft_reset_q;
    logic next_pci_irq;
    logic next_local_irq;
    logic write_now;
    logic mailbox_raise;
    logic [31:0] strobe_mask;

    assign write_now = psel && penable && pwrite && pready;
    assign strobe_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    // local writes the interrupt-to-host bit of its outgoing mailbox
    assign mailbox_raise = write_now && (paddr == `LH_MAILBOX_OFFSET) && pstrb[3]
        && pwdata[`MAILBOX_IRQ_BIT];

    // host side register
    always_comb begin
        host_side.write_strobe = write_now && (paddr == `HOST_IRQ_OFFSET) && (&pstrb);
        host_side.write_data = pwdata;
        host_side.raise = 10'h000;
        host_side.raise[`BIT_LOCAL_OVF] = local_fifo_overflow; // RULE11
        host_side.raise[`BIT_PCI_OVF] = pci_fifo_overflow; // RULE11
        host_side.raise[`BIT_MAILBOX] = mailbox_raise || host_write_mailbox; // RULE9 RULE16
        host_side.raise[`BIT_EXT_SIGNAL] = ext_signal_event; // RULE9
        host_side.raise[`BIT_DMA_DONE] = dma_done; // RULE12
        host_side.raise[`BIT_TARGET_ABORT] = target_abort; // RULE13
        host_side.raise[`BIT_MASTER_ABORT] = master_abort; // RULE13
        host_side.clear_mailbox = 1'b0; // RULE17
        host_side.mirror = 10'h000;
        host_side.mirror[`BIT_IN_NOT_EMPTY] = inbound_queue_status; // RULE4
        host_side.mirror[`BIT_OUT_NOT_EMPTY] = outbound_queue_status; // RULE5
    end

    // local side register
    always_comb begin
        local_side.write_strobe = write_now && (paddr == `LOCAL_IRQ_OFFSET) && (&pstrb);
        local_side.write_data = pwdata;
        local_side.raise = 10'h000;
        local_side.raise[`BIT_LOCAL_OVF] = local_fifo_overflow; // RULE11
        local_side.raise[`BIT_PCI_OVF] = pci_fifo_overflow; // RULE11
        local_side.raise[`BIT_MAILBOX] = write_now && (paddr == `HL_MAILBOX_OFFSET)
            && pstrb[3] && pwdata[`MAILBOX_IRQ_BIT]; // RULE10
        local_side.raise[`BIT_DMA_DONE] = dma_done; // RULE12
        local_side.raise[`BIT_TARGET_ABORT] = target_abort; // RULE13
        local_side.raise[`BIT_MASTER_ABORT] = master_abort; // RULE13
        local_side.clear_mailbox = soft_reset && !soft_reset_q; // RULE17
        local_side.mirror = 10'h000;
        local_side.mirror[`BIT_IN_NOT_EMPTY] = inbound_queue_status; // RULE4
        local_side.mirror[`BIT_OUT_NOT_EMPTY] = outbound_queue_status; // RULE5
    end

    irq_bank #(
        .ENABLE_MASK(`HOST_ENABLE_MASK),
        .CLEAR_MASK(`HOST_WRITABLE_MASK)
    ) host_bank (
        .clock(clock),
        .reset_n(reset_n),
        .port(host_side.bank)
    );

    irq_bank #(
        .ENABLE_MASK(`LOCAL_ENABLE_MASK),
        .CLEAR_MASK(`LOCAL_WRITABLE_MASK)
    ) local_bank (
        .clock(clock),
        .reset_n(reset_n),
        .port(local_side.bank)
    );

    // apb phase, read data and mailbox data
    always_comb begin
        next_phase = phase;
        next_pready = 1'b0;
        next_pslverr = 1'b0;
        next_prdata = prdata;
        next_lh_mailbox = lh_mailbox;
        next_hl_mailbox = hl_mailbox;
        case (phase)
            irq_status_pkg::apb_idle: begin
                if (psel && !penable) begin
                    next_phase = irq_status_pkg::apb_access;
                    next_pready = 1'b1;
                    next_prdata = 32'h0000_0000;
                    case (paddr)
                        `HOST_IRQ_OFFSET: next_prdata = host_side.read_value;
                        `LOCAL_IRQ_OFFSET: next_prdata = local_side.read_value;
                        `HL_MAILBOX_OFFSET: next_prdata = hl_mailbox;
                        `LH_MAILBOX_OFFSET: next_prdata = lh_mailbox;
                        default: next_pslverr = 1'b1;
                    endcase
                    if (pwrite) begin
                        next_prdata = 32'h0000_0000;
                    end
                end
            end
            irq_status_pkg::apb_access: begin
                next_phase = irq_status_pkg::apb_idle;
            end
            default: next_phase = irq_status_pkg::apb_idle;
        endcase
        // the interrupt-to-host bit is write only, so keep only the data bytes
        if (write_now && paddr == `LH_MAILBOX_OFFSET) begin
            next_lh_mailbox = ((lh_mailbox & ~strobe_mask) | (pwdata & strobe_mask))
                & 32'h0000_ffff;
        end
        if (write_now && paddr == `HL_MAILBOX_OFFSET) begin
            next_hl_mailbox = ((hl_mailbox & ~strobe_mask) | (pwdata & strobe_mask))
                & 32'h0000_ffff;
        end
        next_soft_reset_q = soft_reset;
        next_pci_irq = host_side.irq; // RULE15
        next_local_irq = local_side.irq; // RULE15
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            phase <= irq_status_pkg::apb_idle;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            lh_mailbox <= 32'h0000_0000;
            hl_mailbox <= 32'h0000_0000;
            soft_reset_q <= 1'b0;
            pci_irq <= 1'b0;
            local_irq <= 1'b0;
        end else begin
            phase <= next_phase;
            pready <= next_pready;
            pslverr <= next_pslverr;
            prdata <= next_prdata;
            lh_mailbox <= next_lh_mailbox;
            hl_mailbox <= next_hl_mailbox;
            soft_reset_q <= next_soft_reset_q;
            pci_irq <= next_pci_irq;
            local_irq <= next_local_irq;
        end
    end

    chk_mailbox_raise: assert property (@(posedge clock) disable iff (!reset_n)
        mailbox_raise |=> host_side.read_value[`BIT_MAILBOX])
        else $error("local mailbox write did not raise host event"); // RULE16
    chk_soft_reset: assert property (@(posedge clock) disable iff (!reset_n)
        (soft_reset && !soft_reset_q && !local_side.raise[`BIT_MAILBOX])
        |=> !local_side.read_value[`BIT_MAILBOX])
        else $error("soft reset left local mailbox event"); // RULE17
    chk_pci_irq: assert property (@(posedge clock) disable iff (!reset_n)
        host_side.irq |=> pci_irq) else $error("pci irq not driven"); // RULE15
    chk_local_irq: assert property (@(posedge clock) disable iff (!reset_n)
        !local_side.irq |=> !local_irq) else $error("local irq stuck"); // RULE15
    cov_host_read: cover property (@(posedge clock) disable iff (!reset_n)
        psel && penable && !pwrite && paddr == `HOST_IRQ_OFFSET);
    cov_soft_reset: cover property (@(posedge clock) disable iff (!reset_n)
        soft_reset && !soft_reset_q);
    cov_mailbox: cover property (@(posedge clock) disable iff (!reset_n) mailbox_raise ##2 pci_irq);
endmodule : dual_side_interrupt_status

// [irq_status_defs.svh]
// register offsets, field positions and reset values of the dual-side interrupt status block
// assumes byte addressing on a 32-bit apb slave
`ifndef IRQ_STATUS_DEFS_SVH
`define IRQ_STATUS_DEFS_SVH
`define HOST_IRQ_OFFSET 12'h4e4
`define HL_MAILBOX_OFFSET 12'h4e8
`define LOCAL_IRQ_OFFSET 12'h4f4
`define LH_MAILBOX_OFFSET 12'h4f8
`define SOFT_RESET_OFFSET 12'h4e0
`define EVENT_SOURCE_EVENTS 10
`define ENABLE_LSB 16
`define ENABLE_MSB 25
`define STATUS_MSB 9
`define BIT_LOCAL_OVF 0
`define BIT_PCI_OVF 1
`define BIT_RESERVED 2
`define BIT_MAILBOX 3
`define BIT_EXT_SIGNAL 4
`define BIT_DMA_DONE 5
`define BIT_IN_NOT_EMPTY 6
`define BIT_OUT_NOT_EMPTY 7
`define BIT_TARGET_ABORT 8
`define BIT_MASTER_ABORT 9
`define MAILBOX_IRQ_BIT 31
`define SOFT_RESET_BIT 1
`define EVENTS_RESET 10'h000
`define HOST_WRITABLE_MASK 10'h33b
`define LOCAL_WRITABLE_MASK 10'h32b
`define HOST_ENABLE_MASK 10'h3fb
`define LOCAL_ENABLE_MASK 10'h3eb
`endif

// [irq_status_pkg.sv]
// types used by the interrupt status block, not by its register bank
package irq_status_pkg;
    typedef logic [9:0] event_vec_t;
    typedef enum logic [1:0] {
        apb_idle,
        apb_access
    } apb_phase_t;
endpackage : irq_status_pkg

// [irq_bank_if.sv]
// carrier between the top module and one side's enable/status bank
`timescale 1ns/1ps
interface irq_bank_if;
    logic write_strobe;
    logic [31:0] write_data;
    logic [9:0] raise;
    logic clear_mailbox;
    logic [9:0] mirror;
    logic [31:0] read_value;
    logic irq;
    modport owner (output write_strobe, write_data, raise, clear_mailbox, mirror,
        input read_value, irq);
    modport bank (input write_strobe, write_data, raise, clear_mailbox, mirror,
        output read_value, irq);
endinterface : irq_bank_if

// [irq_bank.sv]
// one side's enable field and event status field
// assumes event pulses and mirrors are on the same clock
`timescale 1ns/1ps
`include "irq_status_defs.svh"
module irq_bank #(
    parameter logic [9:0] ENABLE_MASK = 10'h3fb,
    parameter logic [9:0] CLEAR_MASK = 10'h33b
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // owner side
    irq_bank_if.bank port
);
    logic [9:0] enable;
    logic [9:0] status;
    logic [9:0] next_enable;
    logic [9:0] next_status;
    logic [9:0] view;

    always_comb begin
        next_enable = enable;
        next_status = status;
        if (port.write_strobe) begin
            next_enable = port.write_data[`ENABLE_MSB:`ENABLE_LSB] & ENABLE_MASK; // RULE1 RULE8
            next_status = status & ~(port.write_data[`STATUS_MSB:0] & CLEAR_MASK); // RULE3
        end
        if (port.clear_mailbox) begin
            next_status[`BIT_MAILBOX] = 1'b0; // RULE17
        end
        // set wins over clear
        next_status = (next_status | port.raise) & CLEAR_MASK; // RULE9 RULE10 RULE11 RULE12 RULE13
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            enable <= 10'h000; // RULE6
            status <= `EVENTS_RESET; // RULE7
        end else begin
            enable <= next_enable;
            status <= next_status;
        end
    end

    // mirrors are read only and come straight from the queue flags
    assign view = status | (port.mirror & ~CLEAR_MASK & ENABLE_MASK); // RULE4 RULE5 RULE8
    assign port.read_value = {6'h00, enable, 6'h00, view}; // RULE2
    assign port.irq = |(view & enable); // RULE14 RULE15

    chk_write_clears_bit: assert property (@(posedge clock) disable iff (!reset_n)
        port.write_strobe && port.write_data[0] && !port.raise[0] && !port.clear_mailbox
        |=> !status[0]) else $error("status bit 0 not cleared by write of one"); // RULE3
    chk_reserved_zero: assert property (@(posedge clock) disable iff (!reset_n)
        !port.read_value[`BIT_RESERVED] && !port.read_value[`ENABLE_LSB + `BIT_RESERVED])
        else $error("reserved bit reads nonzero"); // RULE8
    chk_mirror_follows: assert property (@(posedge clock) disable iff (!reset_n)
        port.read_value[`BIT_IN_NOT_EMPTY] == port.mirror[`BIT_IN_NOT_EMPTY])
        else $error("inbound mirror mismatch"); // RULE4
    chk_mirror_out: assert property (@(posedge clock) disable iff (!reset_n)
        port.read_value[`BIT_OUT_NOT_EMPTY] == port.mirror[`BIT_OUT_NOT_EMPTY])
        else $error("outbound mirror mismatch"); // RULE5
    chk_raise_sets: assert property (@(posedge clock) disable iff (!reset_n)
        port.raise[`BIT_DMA_DONE] |=> status[`BIT_DMA_DONE])
        else $error("dma event not latched"); // RULE12
    chk_irq_gated: assert property (@(posedge clock) disable iff (!reset_n)
        (enable == 10'h000) |-> !port.irq) else $error("irq with no enables"); // RULE15
    cov_event_irq: cover property (@(posedge clock) disable iff (!reset_n)
        port.raise[`BIT_DMA_DONE] ##1 port.irq);
endmodule : irq_bank

// [event_source_model.sv]
// behavioural model of the logic around the block: event pulses and queue levels
// assumes the bench asks for events at rising edges; each request yields one pulse
`timescale 1ns/1ps
module event_source_model (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // requests from the bench
    input wire logic [6:0] fire,
    input wire logic in_level,
    input wire logic out_level,
    // pins toward the block
    output logic local_fifo_overflow,
    output logic pci_fifo_overflow,
    output logic ext_signal_event,
    output logic dma_done,
    output logic target_abort,
    output logic master_abort,
    output logic host_write_mailbox,
    output logic inbound_queue_status,
    output logic outbound_queue_status
);
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            {host_write_mailbox, master_abort, target_abort, dma_done} <= 4'h0;
            {ext_signal_event, pci_fifo_overflow, local_fifo_overflow} <= 3'h0;
            {outbound_queue_status, inbound_queue_status} <= 2'h0;
        end else begin
            local_fifo_overflow <= fire[0];
            pci_fifo_overflow <= fire[1];
            ext_signal_event <= fire[2];
            dma_done <= fire[3];
            target_abort <= fire[4];
            master_abort <= fire[5];
            host_write_mailbox <= fire[6];
            inbound_queue_status <= in_level;
            outbound_queue_status <= out_level;
        end
    end
endmodule : event_source_model

// [tb.sv]
// self-checking bench: apb master, register model, random events and corner cases
// assumes the block answers every access in one wait-free cycle as handed over
`timescale 1ns/1ps
`include "irq_status_defs.svh"
`define CHECK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
    $display("FAIL %s expected %h seen %h", nm, e, g); end end
module tb;
    logic clock = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, soft_reset = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, r = 32'h918745f4;
    logic [3:0] pstrb = 4'hf;
    logic pready, pslverr, pci_irq, local_irq, err, inq = 0, outq = 0;
    logic [6:0] fire = 7'h00;
    logic lo, po, ex, dd, ta, ma, hm, iq, oq;
    logic [9:0] hen = 10'h0, hst = 10'h0, len = 10'h0, lst = 10'h0;
    int fail_count = 0, n_tests = 0, cyc = 0;
    always #12.5 clock = ~clock;
    event_source_model u_event_source_model (.clock(clock), .reset_n(reset_n), .fire(fire),
        .in_level(inq), .out_level(outq), .local_fifo_overflow(lo), .pci_fifo_overflow(po),
        .ext_signal_event(ex), .dma_done(dd), .target_abort(ta), .master_abort(ma),
        .host_write_mailbox(hm), .inbound_queue_status(iq), .outbound_queue_status(oq));
    dual_side_interrupt_status u_dual_side_interrupt_status (.clock(clock), .reset_n(reset_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .local_fifo_overflow(lo), .pci_fifo_overflow(po), .ext_signal_event(ex),
        .dma_done(dd), .target_abort(ta), .master_abort(ma), .host_write_mailbox(hm),
        .inbound_queue_status(iq), .outbound_queue_status(oq), .soft_reset(soft_reset),
        .pci_irq(pci_irq), .local_irq(local_irq));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
    endfunction : lfsr
    // expected image: enables high, status low, queue mirrors live at 6 and 7
    function automatic logic [31:0] img(input logic [9:0] en, input logic [9:0] st);
        return {6'h00, en, 6'h00, st | {2'b00, outq, inq, 6'h00}};
    endfunction : img
    task automatic end_sim();
        $display("tests %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : end_sim
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            end_sim();
        end
    end
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
            input logic [3:0] s);
        @(posedge clock);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
        @(posedge clock);
        penable <= 1;
        // only the bench timeout ends a wait for the answer
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0; penable <= 0;
    endtask : apb
    // write to an interrupt register and update the model as the block should
    task automatic wr_irq(input logic host, input logic [31:0] d, input logic [3:0] s);
        apb(1, host ? `HOST_IRQ_OFFSET : `LOCAL_IRQ_OFFSET, d, s);
        if (s == 4'hf && host) begin
            hen = d[25:16] & `HOST_ENABLE_MASK;
            hst = hst & ~(d[9:0] & `HOST_WRITABLE_MASK);
        end else if (s == 4'hf) begin
            len = d[25:16] & `LOCAL_ENABLE_MASK;
            lst = lst & ~(d[9:0] & `LOCAL_WRITABLE_MASK);
        end
    endtask : wr_irq
    task automatic check_all();
        apb(0, `HOST_IRQ_OFFSET, 32'h0, 4'hf);
        `CHECK("host reg", img(hen, hst), rd)
        apb(0, `LOCAL_IRQ_OFFSET, 32'h0, 4'hf);
        `CHECK("local reg", img(len, lst), rd)
        `CHECK("mapped err", 1'b0, err)
        `CHECK("pci irq", |(img(hen, hst) >> 16 & img(hen, hst)), pci_irq)
        `CHECK("local irq", |(img(len, lst) >> 16 & img(len, lst)), local_irq)
    endtask : check_all
    task automatic pulse(input logic [6:0] v);
        @(posedge clock) fire <= v;
        @(posedge clock) fire <= 7'h00;
        repeat (3) @(posedge clock);
        hst |= {v[5:4], 2'b00, v[3], v[2], v[6], 1'b0, v[1:0]};
        lst |= {v[5:4], 2'b00, v[3], 2'b00, 1'b0, v[1:0]};
    endtask : pulse
    initial begin
        repeat (3) @(posedge clock);
        reset_n <= 1;
        check_all();
        `CHECK("reset status", 10'h000, rd[9:0])
        wr_irq(1, 32'hffffffff, 4'hf);
        wr_irq(0, 32'hffffffff, 4'hf);
        @(posedge clock) inq <= 1;
        repeat (4) @(posedge clock);
        check_all();
        wr_irq(1, 32'h03ff03ff, 4'hf);
        check_all();
        pulse(7'h7f);
        wr_irq(0, 32'h03ff0000, 4'h7);
        check_all();
        apb(1, `HL_MAILBOX_OFFSET, 32'h80001234, 4'hf);
        lst[3] = 1'b1;
        apb(0, `HL_MAILBOX_OFFSET, 32'h0, 4'hf);
        `CHECK("mailbox data", 32'h00001234, rd)
        check_all();
        @(posedge clock) soft_reset <= 1;
        repeat (3) @(posedge clock);
        soft_reset <= 0;
        lst[3] = 1'b0;
        check_all();
        apb(0, 12'h400, 32'h0, 4'hf);
        `CHECK("unmapped err", 1'b1, err)
        `CHECK("unmapped data", 32'h0, rd)
        for (int i = 0; i < 60; i++) begin
            r = lfsr(r);
            case (r[1:0])
                2'd0: begin
                    inq <= r[9];
                    outq <= r[10];
                    pulse(r[17:11]);
                end
                2'd1: wr_irq(r[2], lfsr(r), r[3] ? 4'hf : 4'h7);
                2'd2: wr_irq(r[2], {6'h00, r[31:22], 16'h0000}, 4'hf);
                default: begin
                    apb(1, r[2] ? `LH_MAILBOX_OFFSET : `HL_MAILBOX_OFFSET,
                        {r[4], 31'h0}, 4'hf);
                    if (r[2]) hst[3] = hst[3] | r[4];
                    else lst[3] = lst[3] | r[4];
                end
            endcase
            check_all();
        end
        end_sim();
    end
endmodule : tb
